//--- verilog/timer_flag_pkg.sv
// Purpose: Constants for the timer status-flag and bus access unit
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: Flag positions are shared by status, enable and clear registers
package timer_flag_pkg;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN = 8'h04;
	localparam logic [7:0] OFS_CNT0_HI = 8'h08;
	localparam logic [7:0] OFS_CNT0_LO = 8'h0c;
	localparam logic [7:0] OFS_CAP_HI = 8'h10;
	localparam logic [7:0] OFS_CAP_LO = 8'h14;
	localparam logic [7:0] OFS_OFFSET_BASE = 8'h18;
	localparam logic [7:0] OFS_GENERAL = 8'h1c;
	localparam logic [7:0] OFS_OCMP_HI = 8'h20;
	localparam logic [7:0] OFS_OCMP_LO = 8'h24;
	localparam logic [7:0] OFS_CYCLE = 8'h28;
	localparam logic [7:0] OFS_DOWN = 8'h2c;
	localparam logic [7:0] OFS_START = 8'h30;
	localparam logic [7:0] OFS_FREE_RUN = 8'h34;
	localparam logic [7:0] OFS_INTERVAL = 8'h38;
	localparam logic [7:0] OFS_CLEAR = 8'h3c;

	localparam int NUM_FLAGS = 9;
	localparam int FLG_CAPTURE = 0;
	localparam int FLG_CAP_CMP = 1;
	localparam int FLG_MATCH_GEN = 2;
	localparam int FLG_MATCH_OCMP = 3;
	localparam int FLG_MATCH_CYC = 4;
	localparam int FLG_OVF32 = 5;
	localparam int FLG_OVF16 = 6;
	localparam int FLG_UNDERFLOW = 7;
	localparam int FLG_INTERVAL = 8;
	localparam logic [8:0] DMA_CLR_MASK = 9'h00b;

	localparam int START_CNT0 = 0;
	localparam int START_FREE = 1;
	localparam int START_DOWN = 2;
	localparam int ITV_DMA_BIT = 0;
	localparam int ITV_EN_LSB = 4;
	localparam int ITV_CNT_LSB = 10;

	localparam logic [31:0] CNT32_MAX = 32'hffffffff;
	localparam logic [15:0] CNT16_MAX = 16'hffff;
	localparam logic [15:0] DOWN_LAST = 16'h0001;
	localparam logic [15:0] RST_CYCLE = 16'hffff;
	localparam logic [31:0] RST_OCMP = 32'hffffffff;
	localparam logic [15:0] RST_GENERAL = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_flag_pkg

//--- verilog/edge_if.sv
// Purpose: Carries one outside pin level and its synchronised rise pulse
// Assumes: Pin is asynchronous to the system clock
// Notes: One instance per pin
`timescale 1ns/100ps
interface edge_if;
	logic pin;
	logic rise;
	modport det (input pin, output rise);
	modport use_side (output pin, input rise);
endinterface : edge_if

//--- verilog/edge_sync.sv
// Purpose: Two-flop synchroniser with rising-edge pulse
// Assumes: Pin held at least two system clocks per level
// Notes: Rise pulse is one clock wide, two edges after the pin rises
`timescale 1ns/100ps
module edge_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	edge_if.det port
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// First flop feeds only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= port.pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign port.rise = sync_r & ~prev_r;

	chk_rise_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
		port.rise |=> !port.rise) else $error("rise pulse longer than one cycle");
endmodule : edge_sync

//--- verilog/timer_flag_unit.sv
// Purpose: Timer status flags, interrupt lines and split bus access
// Assumes: Counter, capture and down-count clocks arrive as pins
// Notes: Channel functions outside this block only send events here
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module timer_flag_unit import timer_flag_pkg::*; (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	output logic [1:0] O_AXI_BRESP,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	input wire logic [7:0] I_AXI_ARADDR,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	input wire logic I_CAPTURE_PIN,
	input wire logic I_COUNT_CLK_PIN,
	input wire logic I_DOWN_CLK_PIN,
	input wire logic I_ONESHOT_CLR,
	input wire logic I_DMA_CLR,
	output logic O_DMA_REQ,
	output logic [8:0] O_IRQ_LINES,
	output logic O_IRQ
);
	default clocking dflt @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);

	edge_if cap_if ();
	edge_if cnt_if ();
	edge_if down_if ();
	assign cap_if.pin = I_CAPTURE_PIN;
	assign cnt_if.pin = I_COUNT_CLK_PIN;
	assign down_if.pin = I_DOWN_CLK_PIN;

	edge_sync u_cap_sync (.i_clk(I_CLK_SYS), .i_rst(I_SYS_RST), .port(cap_if));
	edge_sync u_cnt_sync (.i_clk(I_CLK_SYS), .i_rst(I_SYS_RST), .port(cnt_if));
	edge_sync u_down_sync (.i_clk(I_CLK_SYS), .i_rst(I_SYS_RST),
		.port(down_if));

	// Bus slave state
	logic aw_ok_r;
	logic w_ok_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_go;
	logic rd_go;
	logic [7:0] rd_addr;
	logic word16;
	logic wr_mapped;
	logic [31:0] rd_nxt;
	logic rd_mapped;

	// Timer state
	logic [NUM_FLAGS-1:0] status_r;
	logic [NUM_FLAGS-1:0] seen_r;
	logic [NUM_FLAGS-1:0] irq_en_r;
	logic [NUM_FLAGS-1:0] set_v;
	logic [NUM_FLAGS-1:0] clr_v;
	logic [31:0] cnt0_r;
	logic [31:0] cnt0_nxt;
	logic [15:0] cnt0_wbuf_r;
	logic [15:0] cnt0_rbuf_r;
	logic [31:0] cap_r;
	logic [15:0] cap_rbuf_r;
	logic [15:0] offset_base_r;
	logic [15:0] general_r;
	logic [31:0] ocmp_r;
	logic [15:0] ocmp_wbuf_r;
	logic [15:0] cycle_r;
	logic [15:0] free_r;
	logic [15:0] down_r;
	logic armed_r;
	logic clr_pend_r;
	logic [23:0] start_r;
	logic start_pend_r;
	logic [7:0] start3_data_r;
	logic [7:0] itv_r;
	logic tick0;
	logic tick1;
	logic dtick;
	logic capture;
	logic match_gen;
	logic match_ocmp;
	logic match_cyc;
	logic ovf32;
	logic ovf16;
	logic interval;
	logic [3:0] itv_rise;
	logic dma_en;

	assign O_AXI_AWREADY = ~aw_ok_r;
	assign O_AXI_WREADY = ~w_ok_r;
	assign O_AXI_ARREADY = ~rvalid_r;
	assign O_AXI_BVALID = bvalid_r;
	assign O_AXI_BRESP = bresp_r;
	assign O_AXI_RVALID = rvalid_r;
	assign O_AXI_RDATA = rdata_r;
	assign O_AXI_RRESP = rresp_r;

	assign wr_go = aw_ok_r & w_ok_r & ~bvalid_r;
	assign rd_go = I_AXI_ARVALID & ~rvalid_r;
	assign rd_addr = {I_AXI_ARADDR[7:2], 2'b00};
	assign word16 = (w_strb_r[1:0] == 2'b11);

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			aw_ok_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (I_AXI_AWVALID && !aw_ok_r) begin
			aw_ok_r <= 1'b1;
			aw_addr_r <= {I_AXI_AWADDR[7:2], 2'b00};
		end else if (wr_go) begin
			aw_ok_r <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			w_ok_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (I_AXI_WVALID && !w_ok_r) begin
			w_ok_r <= 1'b1;
			w_data_r <= I_AXI_WDATA;
			w_strb_r <= I_AXI_WSTRB;
		end else if (wr_go) begin
			w_ok_r <= 1'b0;
		end
	end

	always_comb begin
		case (aw_addr_r)
			OFS_STATUS, OFS_IRQ_EN, OFS_CNT0_HI, OFS_CNT0_LO, OFS_GENERAL,
			OFS_OCMP_HI, OFS_OCMP_LO, OFS_CYCLE, OFS_DOWN, OFS_START,
			OFS_FREE_RUN, OFS_INTERVAL, OFS_CLEAR: wr_mapped = 1'b1;
			// Capture and offset base take no writes
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (I_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read mux; unused bits read zero
	always_comb begin
		rd_nxt = 32'h00000000;
		rd_mapped = 1'b1;
		case (rd_addr)
			OFS_STATUS: rd_nxt[8:0] = status_r;
			OFS_IRQ_EN: rd_nxt[8:0] = irq_en_r;
			OFS_CNT0_HI: rd_nxt[15:0] = cnt0_r[31:16];
			OFS_CNT0_LO: rd_nxt[15:0] = cnt0_rbuf_r;
			OFS_CAP_HI: rd_nxt[15:0] = cap_r[31:16];
			OFS_CAP_LO: rd_nxt[15:0] = cap_rbuf_r;
			OFS_OFFSET_BASE: rd_nxt[15:0] = offset_base_r;
			OFS_GENERAL: rd_nxt[15:0] = general_r;
			OFS_OCMP_HI: rd_nxt[15:0] = ocmp_r[31:16];
			OFS_OCMP_LO: rd_nxt[15:0] = ocmp_r[15:0];
			OFS_CYCLE: rd_nxt[15:0] = cycle_r;
			OFS_DOWN: rd_nxt[15:0] = down_r;
			OFS_START: rd_nxt[31:8] = start_r;
			OFS_FREE_RUN: rd_nxt[15:0] = free_r;
			OFS_INTERVAL: rd_nxt[15:8] = itv_r;
			OFS_CLEAR: rd_nxt = 32'h00000000;
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_nxt;
			rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (I_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// Events
	assign tick0 = cnt_if.rise & start_r[16 + START_CNT0];
	assign tick1 = cnt_if.rise & start_r[16 + START_FREE];
	assign dtick = down_if.rise & start_r[16 + START_DOWN];
	assign capture = cap_if.rise;
	assign cnt0_nxt = cnt0_r + 32'h00000001;
	assign match_ocmp = tick0 & (cnt0_r == ocmp_r);
	assign match_gen = tick1 & (free_r == general_r);
	assign match_cyc = tick1 & (free_r == cycle_r);
	assign ovf32 = tick0 & (cnt0_r == CNT32_MAX);
	assign ovf16 = tick1 & (free_r == CNT16_MAX);
	assign itv_rise = ~cnt0_r[ITV_CNT_LSB +: 4] & cnt0_nxt[ITV_CNT_LSB +: 4];
	assign interval = tick0 & |(itv_rise & itv_r[ITV_EN_LSB +: 4]);
	assign dma_en = itv_r[ITV_DMA_BIT];

	always_comb begin
		set_v = '0;
		set_v[FLG_CAPTURE] = capture;
		set_v[FLG_CAP_CMP] = capture | match_gen | match_ocmp | match_cyc;
		set_v[FLG_MATCH_GEN] = match_gen;
		set_v[FLG_MATCH_OCMP] = match_ocmp;
		set_v[FLG_MATCH_CYC] = match_cyc;
		set_v[FLG_OVF32] = ovf32;
		set_v[FLG_OVF16] = ovf16;
		set_v[FLG_UNDERFLOW] = dtick & armed_r;
		set_v[FLG_INTERVAL] = interval;
	end

	always_comb begin
		clr_v = '0;
		if (wr_go && aw_addr_r == OFS_STATUS && word16) begin
			clr_v = seen_r & ~w_data_r[8:0];
		end
		if (wr_go && aw_addr_r == OFS_CLEAR && word16) begin
			clr_v = clr_v | w_data_r[8:0];
		end
		if (I_DMA_CLR && dma_en) begin
			clr_v = clr_v | DMA_CLR_MASK;
		end
		if (dtick && clr_pend_r) begin
			clr_v[FLG_UNDERFLOW] = 1'b1;
		end
	end

	// Set beats clear in the same cycle so no event is lost
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~clr_v) | set_v;
		end
	end

	// Remembers which set flags software has read
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			seen_r <= '0;
		end else if (rd_go && rd_addr == OFS_STATUS) begin
			seen_r <= (seen_r | status_r) & ~clr_v;
		end else begin
			seen_r <= seen_r & ~clr_v;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			irq_en_r <= '0;
		end else if (wr_go && aw_addr_r == OFS_IRQ_EN && word16) begin
			irq_en_r <= w_data_r[8:0];
		end
	end

	assign O_IRQ_LINES = status_r & irq_en_r;
	assign O_IRQ = |O_IRQ_LINES;
	assign O_DMA_REQ = dma_en & (status_r[FLG_CAPTURE] |
		status_r[FLG_MATCH_OCMP]);

	// 32-bit counter: bus load beats counting
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cnt0_r <= 32'h00000000;
		end else if (wr_go && aw_addr_r == OFS_CNT0_LO && word16) begin
			cnt0_r <= {cnt0_wbuf_r, w_data_r[15:0]};
		end else if (tick0) begin
			cnt0_r <= cnt0_nxt;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cnt0_wbuf_r <= 16'h0000;
			ocmp_wbuf_r <= 16'h0000;
		end else if (wr_go && word16) begin
			if (aw_addr_r == OFS_CNT0_HI) begin
				cnt0_wbuf_r <= w_data_r[15:0];
			end
			if (aw_addr_r == OFS_OCMP_HI) begin
				ocmp_wbuf_r <= w_data_r[15:0];
			end
		end
	end

	// Lower halves frozen at the upper-half read for coherent pairs
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cnt0_rbuf_r <= 16'h0000;
			cap_rbuf_r <= 16'h0000;
		end else if (rd_go) begin
			if (rd_addr == OFS_CNT0_HI) begin
				cnt0_rbuf_r <= cnt0_r[15:0];
			end
			if (rd_addr == OFS_CAP_HI) begin
				cap_rbuf_r <= cap_r[15:0];
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cap_r <= 32'h00000000;
			offset_base_r <= 16'h0000;
		end else if (capture) begin
			cap_r <= cnt0_r;
			offset_base_r <= cnt0_r[15:0];
		end
	end

	// Capture wins over a bus write in the same cycle
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			general_r <= RST_GENERAL;
		end else if (capture) begin
			general_r <= cnt0_r[15:0];
		end else if (wr_go && aw_addr_r == OFS_GENERAL && word16) begin
			general_r <= w_data_r[15:0];
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ocmp_r <= RST_OCMP;
		end else if (wr_go && aw_addr_r == OFS_OCMP_LO && word16) begin
			ocmp_r <= {ocmp_wbuf_r, w_data_r[15:0]};
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cycle_r <= RST_CYCLE;
		end else if (wr_go && aw_addr_r == OFS_CYCLE && word16) begin
			cycle_r <= w_data_r[15:0];
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			free_r <= 16'h0000;
		end else if (wr_go && aw_addr_r == OFS_FREE_RUN && word16) begin
			free_r <= w_data_r[15:0];
		end else if (tick1) begin
			free_r <= free_r + 16'h0001;
		end
	end

	// Down-counter sticks at zero instead of wrapping
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			down_r <= 16'h0000;
		end else if (I_ONESHOT_CLR) begin
			down_r <= 16'h0000;
		end else if (wr_go && aw_addr_r == OFS_DOWN && word16) begin
			down_r <= w_data_r[15:0];
		end else if (dtick && down_r != 16'h0000) begin
			down_r <= down_r - 16'h0001;
		end
	end

	// Underflow is flagged one down-count pulse after reaching zero
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			armed_r <= 1'b0;
			clr_pend_r <= 1'b0;
		end else if (I_ONESHOT_CLR) begin
			armed_r <= 1'b0;
			clr_pend_r <= 1'b1;
		end else if (dtick) begin
			armed_r <= (down_r == DOWN_LAST);
			clr_pend_r <= 1'b0;
		end
	end

	// Start bytes: upper pair now, third byte one cycle later
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			start_r <= 24'h000000;
			start_pend_r <= 1'b0;
			start3_data_r <= 8'h00;
		end else begin
			start_pend_r <= 1'b0;
			if (start_pend_r) begin
				start_r[7:0] <= start3_data_r;
			end
			if (wr_go && aw_addr_r == OFS_START) begin
				if (w_strb_r[3]) begin
					start_r[23:16] <= w_data_r[31:24];
				end
				if (w_strb_r[2]) begin
					start_r[15:8] <= w_data_r[23:16];
				end
				if (w_strb_r[1]) begin
					start_pend_r <= 1'b1;
					start3_data_r <= w_data_r[15:8];
				end
			end
		end
	end

	// Byte-only register: only the upper lane of the low half counts
	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			itv_r <= 8'h00;
		end else if (wr_go && aw_addr_r == OFS_INTERVAL && w_strb_r[1]) begin
			itv_r <= w_data_r[15:8];
		end
	end

	chk_capture_sets: assert property (
		capture |=> status_r[FLG_CAPTURE] && status_r[FLG_CAP_CMP] &&
		cap_r == $past(cnt0_r) && offset_base_r == $past(cnt0_r[15:0]))
		else $error("capture did not set flags or copy counter");
	chk_match_flag: assert property (
		match_ocmp |=> status_r[FLG_MATCH_OCMP] && status_r[FLG_CAP_CMP])
		else $error("compare match did not set flags");
	chk_overflow_wrap: assert property (
		ovf32 && !(wr_go && aw_addr_r == OFS_CNT0_LO) |=>
		cnt0_r == 32'h00000000 && status_r[FLG_OVF32])
		else $error("32-bit wrap did not set overflow");
	chk_underflow_late: assert property (
		dtick && down_r == DOWN_LAST && !I_ONESHOT_CLR |=>
		!$rose(status_r[FLG_UNDERFLOW]) ##0 armed_r)
		else $error("underflow flagged on the step itself");
	chk_down_hold: assert property (
		down_r == 16'h0000 && !(wr_go && aw_addr_r == OFS_DOWN) |=>
		down_r == 16'h0000)
		else $error("down-counter left zero without a write");
	chk_oneshot_clear: assert property (
		dtick && clr_pend_r && !I_ONESHOT_CLR |=> !status_r[FLG_UNDERFLOW])
		else $error("forced clear did not drop underflow");
	chk_interval_set: assert property (
		interval |=> status_r[FLG_INTERVAL])
		else $error("interval rise did not set flag");
	chk_clear_after_read: assert property (
		$fell(status_r[FLG_OVF32]) |-> $past(seen_r[FLG_OVF32]) ||
		$past(wr_go && aw_addr_r == OFS_CLEAR))
		else $error("flag cleared without prior read");
	chk_read_pair: assert property (
		rd_go && rd_addr == OFS_CNT0_HI |=>
		rdata_r[15:0] == $past(cnt0_r[31:16]) &&
		cnt0_rbuf_r == $past(cnt0_r[15:0]))
		else $error("upper read did not buffer lower half");
	chk_start_split: assert property (
		wr_go && aw_addr_r == OFS_START && w_strb_r[1] |=>
		start_pend_r ##1 start_r[7:0] == $past(start3_data_r))
		else $error("third start byte not written one cycle later");
endmodule : timer_flag_unit

//--- verif/dma_model.sv
// Purpose: Behavioural transfer engine answering the block's DMA request
// Assumes: Request is a level that drops once the flags are cleared
// Notes: Slow mode waits six clocks before the clear pulse
`timescale 1ns/100ps
module dma_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_slow,
	input wire logic i_req,
	output logic o_clr
);
	int wait_cnt;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_clr <= 1'b0;
			wait_cnt <= 0;
		end else if (o_clr || !i_req) begin
			// One pulse per request; never hold the clear high
			o_clr <= 1'b0;
			wait_cnt <= 0;
		end else if (wait_cnt >= (i_slow ? 6 : 1)) begin
			o_clr <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule : dma_model

//--- verif/testbench.sv
// Purpose: Self-checking bench for the timer flag and bus access unit
// Assumes: Bench is the bus master; dma_model answers DMA requests
// Notes: Pins are held six clocks per pulse to clear the synchroniser
`timescale 1ns/100ps
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("wrong value at %0t: got %h want %h", $time, g, e); \
	end \
end
module testbench import timer_flag_pkg::*;;
	logic clk = 0, rst = 1, oneshot = 0, slow = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, v;
	logic [3:0] wstrb = 0;
	logic [2:0] pins = 0;
	logic [1:0] bresp, rresp;
	logic [8:0] irq_lines;
	logic awready, wready, bvalid, arready, rvalid, irq, dma_req, dma_clr;
	int miscompares = 0, n_checks = 0;

	always #50 clk = ~clk;

	timer_flag_unit dut_u (.I_CLK_SYS(clk), .I_SYS_RST(rst),
		.I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
		.I_AXI_AWADDR(awaddr), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
		.I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .O_AXI_BVALID(bvalid),
		.I_AXI_BREADY(bready), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arvalid),
		.O_AXI_ARREADY(arready), .I_AXI_ARADDR(araddr),
		.O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .O_AXI_RDATA(rdata),
		.O_AXI_RRESP(rresp), .I_CAPTURE_PIN(pins[0]),
		.I_COUNT_CLK_PIN(pins[1]), .I_DOWN_CLK_PIN(pins[2]),
		.I_ONESHOT_CLR(oneshot), .I_DMA_CLR(dma_clr), .O_DMA_REQ(dma_req),
		.O_IRQ_LINES(irq_lines), .O_IRQ(irq));

	dma_model dma_u (.i_clk(clk), .i_rst(rst), .i_slow(slow),
		.i_req(dma_req), .o_clr(dma_clr));

	function automatic logic [31:0] hi(input logic [31:0] x);
		return {16'h0000, x[31:16]};
	endfunction : hi

	function automatic logic [31:0] lo(input logic [31:0] x);
		return {16'h0000, x[15:0]};
	endfunction : lo

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
			// A missing answer counts as a mismatch
			if (n > 40) begin
				miscompares++;
				$display("wrong value at %0t: write timed out", $time);
				break;
			end
		end
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
			if (n > 40) begin
				miscompares++;
				$display("wrong value at %0t: read timed out", $time);
				break;
			end
		end
		rready <= 1'b0;
		`CHK(rdata, e)
		`CHK(rresp, er)
	endtask : rd

	// Six clocks high and eight low keeps the pin above the synchroniser minimum
	task automatic pulse(input int k);
		@(posedge clk);
		pins[k] <= 1'b1;
		repeat (6) @(posedge clk);
		pins[k] <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : pulse

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	initial begin
		#(2_000_000);
		miscompares++;
		report_and_stop();
	end

	initial begin
		void'($urandom(18));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_CYCLE, lo(RST_CYCLE), RESP_OKAY);
		rd(OFS_GENERAL, lo(RST_GENERAL), RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		tdone("reset");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? CNT32_MAX : $urandom;
			wr(OFS_CNT0_HI, hi(v), 4'h3, RESP_OKAY);
			wr(OFS_CNT0_LO, lo(v), 4'h3, RESP_OKAY);
			rd(OFS_CNT0_HI, hi(v), RESP_OKAY);
			rd(OFS_CNT0_LO, lo(v), RESP_OKAY);
		end
		wr(OFS_CAP_HI, 32'h1, 4'h3, RESP_SLVERR);
		wr(OFS_OFFSET_BASE, 32'h1, 4'h3, RESP_SLVERR);
		v = $urandom;
		wr(OFS_GENERAL, lo(v), 4'h3, RESP_OKAY);
		wr(OFS_GENERAL, 32'h0, 4'h1, RESP_OKAY);
		rd(OFS_GENERAL, lo(v), RESP_OKAY);
		tdone("split access");
		wr(OFS_CNT0_HI, 32'h0, 4'h3, RESP_OKAY);
		wr(OFS_CNT0_LO, 32'h3ff, 4'h3, RESP_OKAY);
		wr(OFS_INTERVAL, 32'h1000, 4'h2, RESP_OKAY);
		wr(OFS_START, 32'h01000000, 4'h8, RESP_OKAY);
		pulse(1);
		wr(OFS_START, 32'h0, 4'h8, RESP_OKAY);
		rd(OFS_STATUS, 32'h100, RESP_OKAY);
		rd(OFS_CNT0_HI, 32'h0, RESP_OKAY);
		rd(OFS_CNT0_LO, 32'h400, RESP_OKAY);
		wr(OFS_CLEAR, 32'h100, 4'h3, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		tdone("interval");
		wr(OFS_IRQ_EN, 32'h1, 4'h3, RESP_OKAY);
		pulse(0);
		`CHK(irq, 1'b1)
		wr(OFS_STATUS, 32'h0, 4'h3, RESP_OKAY);
		rd(OFS_STATUS, 32'h3, RESP_OKAY);
		rd(OFS_CAP_HI, 32'h0, RESP_OKAY);
		rd(OFS_CAP_LO, 32'h400, RESP_OKAY);
		wr(OFS_STATUS, 32'h0, 4'h3, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		`CHK(irq, 1'b0)
		tdone("capture");
		wr(OFS_INTERVAL, 32'h100, 4'h2, RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			slow <= i[0];
			pulse(0);
			repeat (12) @(posedge clk);
			rd(OFS_STATUS, 32'h0, RESP_OKAY);
			`CHK(dma_req, 1'b0)
		end
		wr(OFS_INTERVAL, 32'h0, 4'h2, RESP_OKAY);
		tdone("dma clear");
		wr(OFS_FREE_RUN, lo(CNT16_MAX), 4'h3, RESP_OKAY);
		wr(OFS_START, 32'h02000000, 4'h8, RESP_OKAY);
		pulse(1);
		// General holds the last captured count, so only cycle matches
		rd(OFS_STATUS, 32'h052, RESP_OKAY);
		`CHK(irq_lines, 9'h000)
		wr(OFS_STATUS, 32'h0, 4'h3, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		tdone("overflow");
		v = $urandom;
		wr(OFS_OCMP_HI, hi(v), 4'h3, RESP_OKAY);
		wr(OFS_OCMP_LO, lo(v), 4'h3, RESP_OKAY);
		rd(OFS_OCMP_HI, hi(v), RESP_OKAY);
		rd(OFS_OCMP_LO, lo(v), RESP_OKAY);
		wr(OFS_OCMP_HI, hi(CNT32_MAX), 4'h3, RESP_OKAY);
		wr(OFS_OCMP_LO, lo(CNT32_MAX), 4'h3, RESP_OKAY);
		wr(OFS_CNT0_HI, hi(CNT32_MAX), 4'h3, RESP_OKAY);
		wr(OFS_CNT0_LO, lo(CNT32_MAX), 4'h3, RESP_OKAY);
		wr(OFS_START, 32'h01000000, 4'h8, RESP_OKAY);
		pulse(1);
		wr(OFS_START, 32'h0, 4'h8, RESP_OKAY);
		// Wrap of the wide counter also passes the compare value
		rd(OFS_STATUS, 32'h02a, RESP_OKAY);
		rd(OFS_CNT0_HI, 32'h0, RESP_OKAY);
		rd(OFS_CNT0_LO, 32'h0, RESP_OKAY);
		wr(OFS_STATUS, 32'h0, 4'h3, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		tdone("wide overflow");
		wr(OFS_START, 32'h00a55a00, 4'hf, RESP_OKAY);
		rd(OFS_START, 32'h00a55a00, RESP_OKAY);
		wr(OFS_START, 32'h00ff0000, 4'h4, RESP_OKAY);
		rd(OFS_START, 32'h00ff5a00, RESP_OKAY);
		tdone("start lanes");
		wr(OFS_DOWN, lo(DOWN_LAST), 4'h3, RESP_OKAY);
		wr(OFS_START, 32'h04000000, 4'h8, RESP_OKAY);
		pulse(2);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		pulse(2);
		rd(OFS_STATUS, 32'h080, RESP_OKAY);
		pulse(2);
		rd(OFS_DOWN, 32'h0, RESP_OKAY);
		@(posedge clk);
		oneshot <= 1'b1;
		@(posedge clk);
		oneshot <= 1'b0;
		rd(OFS_STATUS, 32'h080, RESP_OKAY);
		pulse(2);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		tdone("underflow");
		report_and_stop();
	end
endmodule : testbench
